// >>> hw/rly_pkg.sv
// relay control constants and the dusk/dawn detector
package rly_pkg;
  // clock and time base
  localparam int CLK_PERIOD_NS = 10;
  localparam int SECOND_NS     = 1_000_000_000;
  localparam int SEC_CYCLES    = SECOND_NS / CLK_PERIOD_NS;
  localparam logic [5:0]  SEC_PER_MIN  = 6'h3c;
  localparam logic [10:0] MIN_PER_DAY  = 11'h5a0;
  localparam logic [2:0]  DAYS_PER_WK  = 3'h7;
  // per-output register words, output k at byte 0x40*k
  localparam logic [3:0] REG_MODE   = 4'h0;
  localparam logic [3:0] REG_FUNC   = 4'h1;
  localparam logic [3:0] REG_DD     = 4'h2;
  localparam logic [3:0] REG_EVE    = 4'h3;
  localparam logic [3:0] REG_NIGHT  = 4'h4;
  localparam logic [3:0] REG_MORN   = 4'h5;
  localparam logic [3:0] REG_TIMER0 = 4'h6;
  localparam logic [3:0] REG_LAST   = 4'hd;
  localparam int         REG_COUNT  = 14;
  localparam int         NUM_TIMERS = 4;
  // global registers
  localparam logic [7:0] ADDR_CTRL   = 8'hc0;
  localparam logic [7:0] ADDR_CLOCK  = 8'hc4;
  localparam logic [7:0] ADDR_STATUS = 8'hc8;
  localparam logic [1:0] GLOBAL_PAGE = 2'h3;
  // field positions
  localparam int FUNC_EVE   = 0;
  localparam int FUNC_NIGHT = 1;
  localparam int FUNC_MORN  = 2;
  localparam int FUNC_TMR   = 3;
  localparam int DAYS_LSB   = 16;
  localparam int VOLT_BIT   = 24;
  localparam int NIGHT_BIT  = 16;
  localparam int SEEN_BIT   = 17;
  localparam int TRIP_LSB   = 8;
  // reset values and masks
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] MASK_MODE  = 32'h0000_0003;
  localparam logic [31:0] MASK_FUNC  = 32'h0000_007f;
  localparam logic [31:0] MASK_TIMER = 32'h007f_07ff;
  localparam logic [31:0] MASK_CTRL  = 32'h01ff_ffff;
  localparam logic [31:0] MASK_CLOCK = 32'h0007_07ff;
  localparam logic [31:0] MASK_ALL   = 32'hffff_ffff;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    RLY_MODE_OFF  = 2'h0,
    RLY_MODE_ON   = 2'h1,
    RLY_MODE_AUTO = 2'h2
  } rly_mode_type;

  typedef enum logic [1:0] {
    RLY_DL_DAY   = 2'b01,
    RLY_DL_NIGHT = 2'b10
  } rly_daylight_type;
endpackage : rly_pkg

module rly_daylight (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // time base and module level
  input  wire logic        minute_tick,
  input  wire logic [15:0] pv_level,
  input  wire logic [15:0] pv_thresh,
  input  wire logic [7:0]  deb_min,
  // detected light state
  output logic             is_night,
  output logic             dusk,
  output logic             dawn
);
  import rly_pkg::*;

  rly_daylight_type state;
  logic [7:0]       cnt;
  logic             dark;
  logic             opposite;

  // darkness is judged from the module voltage, no light sensor
  assign dark     = pv_level < pv_thresh;
  assign opposite = (state == RLY_DL_DAY) ? dark : !dark;
  assign is_night = state == RLY_DL_NIGHT;

  // a change must persist through deb_min minute ticks; passing clouds reset it
  always_ff @(posedge clk) begin
    dusk <= 1'b0;
    dawn <= 1'b0;
    if (reset) begin
      state <= RLY_DL_DAY;
      cnt   <= 8'h0;
    end else if (!opposite) begin
      cnt <= 8'h0;
    end else if (cnt >= deb_min) begin
      cnt <= 8'h0;
      unique case (state)
        RLY_DL_DAY: begin
          state <= RLY_DL_NIGHT;
          dusk  <= 1'b1;
        end
        RLY_DL_NIGHT: begin
          state <= RLY_DL_DAY;
          dawn  <= 1'b1;
        end
        default: state <= RLY_DL_DAY;
      endcase
    end else if (minute_tick) begin
      cnt <= cnt + 8'h1;
    end
  end
endmodule // rly_daylight

// >>> hw/rly_relay_ctrl.sv
// relay output control: modes, light functions, timers, discharge guard
// Function
// - each output selects forced on, forced off or automatic mode
// - automatic: any enabled function requesting on turns the output on
// - automatic: output drops only when all enabled functions withdraw
// - reaching the discharge threshold forces that output off
// - after trip, stay off until level reaches threshold plus hysteresis
// - each output has its own threshold and hysteresis
// - threshold compares against charge percent or voltage, as configured
// - disabling a function keeps its stored settings
// - enabled functions act only in automatic mode
// - after reset every output is forced off
// - dusk and dawn come from the solar module input
// - evening: on after delay from dusk, for a set duration
// - evening and morning requests end at dawn
// - night: on after delay from dusk, off a set time before dawn; until the first dawn is learned the code holds it on until real dawn
// - morning: on for a duration ending a set time before dawn
// - timer on time applies only on its enabled weekdays
// - timer off time has its own weekday set
// - timers run weekly; an on period may span several days
// - morning waits for one night-to-day change, then tracks dawn
//
// Our own choices: the register offsets and the AXI4-Lite interface to the registers.
module rly_relay_ctrl #(
  parameter int NUM_OUT    = 3,
  parameter int SEC_CYCLES = rly_pkg::SEC_CYCLES
) (
  // clock and reset
  input  wire logic               clk,
  input  wire logic               reset,
  // axi4-lite write address and data
  input  wire logic [7:0]         s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  // axi4-lite write response
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  // axi4-lite read
  input  wire logic [7:0]         s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  // measurements
  input  wire logic [15:0]        batt_soc,
  input  wire logic [15:0]        batt_volt,
  input  wire logic [15:0]        pv_level,
  // relay drives
  output logic [NUM_OUT-1:0]      relay
);
  import rly_pkg::*;

  if (NUM_OUT < 1 || NUM_OUT > 3) begin : g_bad_num
    $error("NUM_OUT must be 1 to 3");
  end
  if (SEC_CYCLES < 1) begin : g_bad_sec
    $error("SEC_CYCLES must be positive");
  end

  // reserved bits of each word, cleared on write so they read zero
  function automatic logic [31:0] word_mask(input logic [7:0] a);
    if (a[7:6] == GLOBAL_PAGE)
      word_mask = (a == ADDR_CTRL) ? MASK_CTRL : MASK_CLOCK;
    else if (a[5:2] == REG_MODE)
      word_mask = MASK_MODE;
    else if (a[5:2] == REG_FUNC)
      word_mask = MASK_FUNC;
    else if (a[5:2] >= REG_TIMER0)
      word_mask = MASK_TIMER;
    else
      word_mask = MASK_ALL;
  endfunction

  // mapped address test, shared by read and write decode
  function automatic logic addr_ok(input logic [7:0] a, input logic wr);
    if (a[7:6] == GLOBAL_PAGE)
      addr_ok = a == ADDR_CTRL || a == ADDR_CLOCK
             || (a == ADDR_STATUS && !wr);
    else
      addr_ok = 32'(a[7:6]) < NUM_OUT && a[5:2] <= REG_LAST;
  endfunction

  // byte lane merge
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  strb);
    for (int i = 0; i < 4; i++)
      merge[8*i +: 8] = strb[i] ? nw[8*i +: 8] : old[8*i +: 8];
  endfunction

  logic [31:0] cfg [NUM_OUT][REG_COUNT];
  logic [31:0] ctrl;
  logic [31:0] sec_cnt;
  logic [5:0]  sec_of_min;
  logic [10:0] minute;
  logic [2:0]  weekday;
  logic        minute_tick;
  logic        is_night;
  logic        dusk;
  logic        dawn;
  logic        dawn_seen;
  logic [10:0] since_dusk;
  logic [10:0] night_len;
  logic [10:0] to_dawn;
  logic [15:0] batt_level;
  logic [NUM_OUT-1:0] tripped;
  logic [NUM_OUT-1:0] next_relay;
  logic        wr_fire;
  logic        wr_ok;
  logic [31:0] next_rdata;

  assign wr_fire = s_axi_awvalid && s_axi_awready;
  assign wr_ok   = addr_ok(s_axi_awaddr, 1'b1);

  // address and data are taken together, one write in flight
  always_ff @(posedge clk) begin
    if (reset) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else begin
      s_axi_awready <= !s_axi_awready && !s_axi_bvalid
                       && s_axi_awvalid && s_axi_wvalid;
      s_axi_wready  <= !s_axi_awready && !s_axi_bvalid
                       && s_axi_awvalid && s_axi_wvalid;
    end
  end

  // write response, slverr for unmapped or read-only words
  always_ff @(posedge clk) begin
    if (reset) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // per-output settings; clearing an enable leaves the rest untouched
  always_ff @(posedge clk) begin
    if (reset) begin
      for (int o = 0; o < NUM_OUT; o++)
        for (int r = 0; r < REG_COUNT; r++)
          cfg[o][r] <= 32'h0; // mode word zero is forced off
    end else if (wr_fire && wr_ok && s_axi_awaddr[7:6] != GLOBAL_PAGE) begin
      cfg[s_axi_awaddr[7:6]][s_axi_awaddr[5:2]] <=
        merge(cfg[s_axi_awaddr[7:6]][s_axi_awaddr[5:2]],
              s_axi_wdata, s_axi_wstrb) & word_mask(s_axi_awaddr);
    end
  end

  // global control: module threshold, debounce, voltage-based guard
  always_ff @(posedge clk) begin
    if (reset)
      ctrl <= CTRL_RESET;
    else if (wr_fire && s_axi_awaddr == ADDR_CTRL)
      ctrl <= merge(ctrl, s_axi_wdata, s_axi_wstrb) & MASK_CTRL;
  end

  // seconds prescaler; long count is a parameter so benches can shorten it
  always_ff @(posedge clk) begin
    minute_tick <= 1'b0;
    if (reset) begin
      sec_cnt    <= 32'h0;
      sec_of_min <= 6'h0;
    end else if (sec_cnt == 32'(SEC_CYCLES - 1)) begin
      sec_cnt <= 32'h0;
      if (sec_of_min == SEC_PER_MIN - 6'h1) begin
        sec_of_min  <= 6'h0;
        minute_tick <= 1'b1;
      end else begin
        sec_of_min <= sec_of_min + 6'h1;
      end
    end else begin
      sec_cnt <= sec_cnt + 32'h1;
    end
  end

  // weekly wall clock; a software write wins over the tick
  always_ff @(posedge clk) begin
    if (reset) begin
      minute  <= 11'h0;
      weekday <= 3'h0;
    end else if (wr_fire && s_axi_awaddr == ADDR_CLOCK) begin
      minute  <= s_axi_wdata[10:0];
      weekday <= s_axi_wdata[DAYS_LSB +: 3];
    end else if (minute_tick) begin
      if (minute == MIN_PER_DAY - 11'h1) begin
        minute  <= 11'h0;
        weekday <= (weekday == DAYS_PER_WK - 3'h1) ? 3'h0 : weekday + 3'h1;
      end else begin
        minute <= minute + 11'h1;
      end
    end
  end

  rly_daylight u_daylight (
    .clk         (clk),
    .reset       (reset),
    .minute_tick (minute_tick),
    .pv_level    (pv_level),
    .pv_thresh   (ctrl[15:0]),
    .deb_min     (ctrl[23:16]),
    .is_night    (is_night),
    .dusk        (dusk),
    .dawn        (dawn)
  );

  // night length is relearned every dawn, so dawn time tracks the seasons
  always_ff @(posedge clk) begin
    if (reset) begin
      since_dusk <= 11'h0;
      night_len  <= 11'h0;
      dawn_seen  <= 1'b0;
    end else if (dusk) begin
      since_dusk <= 11'h0;
    end else if (dawn) begin
      night_len <= since_dusk;
      dawn_seen <= 1'b1;
    end else if (minute_tick && is_night
                 && since_dusk != MIN_PER_DAY - 11'h1) begin
      since_dusk <= since_dusk + 11'h1;
    end
  end

  assign to_dawn    = (night_len > since_dusk) ? night_len - since_dusk
                                               : 11'h0;
  assign batt_level = ctrl[VOLT_BIT] ? batt_volt : batt_soc;

  for (genvar g = 0; g < NUM_OUT; g++) begin : g_out
    logic [16:0]     sd;
    logic [16:0]     td;
    logic [16:0]     reconnect;
    logic [6:0]      fen;
    logic            eve_on;
    logic            night_on;
    logic            morn_on;
    logic            auto_req;
    logic            trip;
    logic [NUM_TIMERS-1:0] tmr_state;
    rly_mode_type    mode;

    assign sd   = {6'h0, since_dusk};
    assign td   = {6'h0, to_dawn};
    assign fen  = cfg[g][REG_FUNC][6:0];
    assign mode = rly_mode_type'(cfg[g][REG_MODE][1:0]);

    // evening window counted from dusk, cut short by dawn
    assign eve_on = fen[FUNC_EVE] && is_night
      && sd >= {1'b0, cfg[g][REG_EVE][15:0]}
      && sd < {1'b0, cfg[g][REG_EVE][15:0]}
            + {1'b0, cfg[g][REG_EVE][31:16]};

    // night: before the first dawn is learned it holds until real dawn
    assign night_on = fen[FUNC_NIGHT] && is_night
      && sd >= {1'b0, cfg[g][REG_NIGHT][15:0]}
      && (!dawn_seen || td > {1'b0, cfg[g][REG_NIGHT][31:16]});

    // morning: window before the learned dawn, dropped at real dawn
    assign morn_on = fen[FUNC_MORN] && is_night && dawn_seen
      && td > {1'b0, cfg[g][REG_MORN][31:16]}
      && td <= {1'b0, cfg[g][REG_MORN][31:16]}
             + {1'b0, cfg[g][REG_MORN][15:0]};

    // timers latch on and off edges, so an on span can cross days
    for (genvar t = 0; t < NUM_TIMERS; t++) begin : g_tmr
      logic [31:0] on_w;
      logic [31:0] off_w;
      assign on_w  = cfg[g][REG_TIMER0 + 4'(2 * t)];
      assign off_w = cfg[g][REG_TIMER0 + 4'(2 * t + 1)];
      always_ff @(posedge clk) begin
        if (reset)
          tmr_state[t] <= 1'b0;
        else if (minute == off_w[10:0] && off_w[DAYS_LSB + weekday])
          tmr_state[t] <= 1'b0;
        else if (minute == on_w[10:0] && on_w[DAYS_LSB + weekday])
          tmr_state[t] <= 1'b1;
      end
    end

    // functions are ORed; off only when every one has let go
    assign auto_req = eve_on || night_on || morn_on
      || |(fen[FUNC_TMR +: NUM_TIMERS] & tmr_state);

    // discharge guard with its own threshold and hysteresis per output
    assign reconnect = {1'b0, cfg[g][REG_DD][15:0]}
                     + {1'b0, cfg[g][REG_DD][31:16]};
    always_ff @(posedge clk) begin
      if (reset)
        trip <= 1'b0;
      else if (batt_level <= cfg[g][REG_DD][15:0])
        trip <= 1'b1;
      else if ({1'b0, batt_level} >= reconnect)
        trip <= 1'b0;
    end
    assign tripped[g] = trip;

    // guard outranks every mode; functions only count in automatic
    always_comb begin
      unique case (mode)
        RLY_MODE_ON:   next_relay[g] = !trip;
        RLY_MODE_AUTO: next_relay[g] = !trip && auto_req;
        default:       next_relay[g] = 1'b0;
      endcase
    end
  end

  // relay pins come straight from flops
  always_ff @(posedge clk) begin
    if (reset)
      relay <= '0;
    else
      relay <= next_relay;
  end

  // read mux
  always_comb begin
    next_rdata = 32'h0;
    if (!addr_ok(s_axi_araddr, 1'b0))
      next_rdata = 32'h0;
    else if (s_axi_araddr == ADDR_CTRL)
      next_rdata = ctrl;
    else if (s_axi_araddr == ADDR_CLOCK)
      next_rdata = {13'h0, weekday, 5'h0, minute};
    else if (s_axi_araddr == ADDR_STATUS) begin
      next_rdata[NUM_OUT-1:0]            = relay;
      next_rdata[TRIP_LSB +: NUM_OUT]    = tripped;
      next_rdata[NIGHT_BIT]              = is_night;
      next_rdata[SEEN_BIT]               = dawn_seen;
    end else
      next_rdata = cfg[s_axi_araddr[7:6]][s_axi_araddr[5:2]];
  end

  // one read in flight; data registered at the address handshake
  always_ff @(posedge clk) begin
    if (reset) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= next_rdata;
        s_axi_rresp  <= addr_ok(s_axi_araddr, 1'b0) ? RESP_OKAY
                                                     : RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule // rly_relay_ctrl

// >>> testbench/rly_relay_ctrl_chk.sv
// port-level assertions for the relay control block
module rly_relay_ctrl_chk #(
  parameter int NUM_OUT    = 3,
  parameter int SEC_CYCLES = 2
) (
  // clock and reset
  input wire logic               clk,
  input wire logic               reset,
  // write channels
  input wire logic               s_axi_awvalid,
  input wire logic               s_axi_awready,
  input wire logic               s_axi_wvalid,
  input wire logic               s_axi_wready,
  input wire logic [1:0]         s_axi_bresp,
  input wire logic               s_axi_bvalid,
  input wire logic               s_axi_bready,
  // read channels
  input wire logic               s_axi_arready,
  input wire logic [31:0]        s_axi_rdata,
  input wire logic [1:0]         s_axi_rresp,
  input wire logic               s_axi_rvalid,
  input wire logic               s_axi_rready,
  // relay drives
  input wire logic [NUM_OUT-1:0] relay
);
  timeunit 1ns;
  timeprecision 1ps;
  // one clock domain, so clocking and disable are given once
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // address and data are only ever taken as a pair
  chk_aw_w_pair: assert property (s_axi_awready == s_axi_wready)
    else $error("write address and data taken apart");
  chk_aw_cause: assert property ($rose(s_axi_awready) |->
    $past(s_axi_awvalid && s_axi_wvalid))
    else $error("write taken without both valids");
  chk_b_follows: assert property (s_axi_awready |=> s_axi_bvalid)
    else $error("write response late");
  chk_b_holds: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  chk_b_clears: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  chk_aw_busy: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write taken while response pending");
  // reads answer on the next cycle and hold until taken
  chk_r_follows: assert property (s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  chk_r_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read data changed before taken");
  chk_ar_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while data pending");
  chk_reset_off: assert property ($fell(reset) |-> relay == '0)
    else $error("relay on straight after reset");

  // main scenarios reached
  cov_relay_on: cover property ($rose(relay[0]));
  cov_wr_err: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
  cov_rd_err: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule // rly_relay_ctrl_chk

bind rly_relay_ctrl rly_relay_ctrl_chk #(
  .NUM_OUT(NUM_OUT), .SEC_CYCLES(SEC_CYCLES)
) i_chk (
  .clk, .reset, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
  .s_axi_rready, .relay
);

// >>> testbench/rly_relay_ctrl_tb_top.sv
// self-checking bench for the relay control block
module rly_relay_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import rly_pkg::*;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = '0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0, s_axi_awready, s_axi_wready;
  logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [15:0] batt_soc = '0, batt_volt = '0, pv_level = '0;
  logic [2:0]  relay;
  int          errors = 0, n_compared = 0;
  logic [31:0] d;
  logic [15:0] thr, hy;
  logic [15:0] lv [5];
  logic        st;
  int          wd;

  always #5 clk = ~clk;

  // one minute is 120 cycles so the day logic runs in reach
  rly_relay_ctrl #(.NUM_OUT(3), .SEC_CYCLES(2)) i_dut (
    .clk, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .batt_soc, .batt_volt, .pv_level, .relay
  );

  // closing report, the only place the run ends
  task automatic end_of_test();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic cmp(string what, logic [31:0] e, logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask

  // a wait that runs out is a failure and stops the run
  task automatic hang(string what);
    errors++;
    $display("mismatch %s expected answer seen timeout", what);
    end_of_test();
  endtask

  // address of word w of output k
  function automatic logic [7:0] ra(int k, logic [3:0] w);
    return 8'(k * 64 + 4 * w);
  endfunction

  // guard: off at or below threshold, on again from threshold plus hysteresis
  function automatic logic dd_on(logic [15:0] l, t, h, logic was);
    if (l <= t) return 1'b0;
    if (17'(l) >= 17'(t) + 17'(h)) return 1'b1;
    return was;
  endfunction

  // address and data offered together, each dropped when taken
  task automatic axi_write(logic [7:0] a, logic [31:0] v, logic [1:0] er);
    int n;
    n = 0;
    @(posedge clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= v;
    s_axi_wstrb   <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (s_axi_bvalid !== 1'b1) begin
      @(posedge clk);
      if (++n > 200) hang("write");
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    cmp("bresp", 32'(er), 32'(s_axi_bresp));
  endtask

  task automatic check_rd(logic [7:0] a, logic [31:0] e, m, logic [1:0] er);
    int n;
    n = 0;
    @(posedge clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    while (s_axi_rvalid !== 1'b1) begin
      @(posedge clk);
      if (++n > 200) hang("read");
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    cmp("rdata", e & m, s_axi_rdata & m);
    cmp("rresp", 32'(er), 32'(s_axi_rresp));
  endtask

  task automatic check_relay(int k, logic v);
    cmp("relay", 32'(v), 32'(relay[k]));
  endtask

  // sampled on the falling edge, where the relay flop has settled
  task automatic wait_relay(int k, logic v, int lim);
    int n;
    n = 0;
    while (relay[k] !== v) begin
      @(negedge clk);
      if (++n > lim) hang("relay");
    end
    check_relay(k, v);
  endtask

  // main sequence
  initial begin
    void'($urandom(48510));
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    for (int k = 0; k < 3; k++) begin
      check_rd(ra(k, REG_MODE), 32'(RLY_MODE_OFF), MASK_ALL, RESP_OKAY);
      check_relay(k, 1'b0);
    end
    // per-output guard walk across both edges of the hysteresis band
    for (int k = 0; k < 3; k++) begin
      thr = 16'h1e + 16'($urandom_range(0, 40));
      hy = 16'($urandom_range(1, 20));
      @(posedge clk) batt_soc <= 16'hffff;
      axi_write(ra(k, REG_DD), {hy, thr}, RESP_OKAY);
      axi_write(ra(k, REG_MODE), 32'(RLY_MODE_ON), RESP_OKAY);
      wait_relay(k, 1'b1, 10);
      st = 1'b1;
      lv = '{thr + 16'h1, thr, thr + hy - 16'h1, thr + hy,
             16'($urandom_range(0, 99))};
      for (int i = 0; i < 5; i++) begin
        @(posedge clk) batt_soc <= lv[i];
        st = dd_on(lv[i], thr, hy, st);
        repeat (4) @(negedge clk);
        check_relay(k, st);
      end
      axi_write(ra(k, REG_MODE), 32'(RLY_MODE_OFF), RESP_OKAY);
      wait_relay(k, 1'b0, 10);
    end
    // guard referenced to voltage while the charge level stays high
    @(posedge clk) batt_soc <= 16'hffff;
    batt_volt <= 16'h0100;
    axi_write(ADDR_CTRL, 32'h0100_0000, RESP_OKAY);
    axi_write(ra(0, REG_DD), 32'h0005_0200, RESP_OKAY);
    axi_write(ra(0, REG_MODE), 32'(RLY_MODE_ON), RESP_OKAY);
    repeat (4) @(negedge clk);
    check_relay(0, 1'b0);
    @(posedge clk) batt_volt <= 16'h0300;
    wait_relay(0, 1'b1, 10);
    // stored settings survive a disable; unmapped and read-only places
    d = $urandom();
    axi_write(ra(2, REG_EVE), d, RESP_OKAY);
    axi_write(ra(2, REG_FUNC), 32'h1, RESP_OKAY);
    axi_write(ra(2, REG_FUNC), 32'h0, RESP_OKAY);
    check_rd(ra(2, REG_EVE), d, MASK_ALL, RESP_OKAY);
    check_rd(8'h38, '0, MASK_ALL, RESP_SLVERR);
    axi_write(ADDR_STATUS, 32'hffff_ffff, RESP_SLVERR);
    // timer on a wrong weekday, then right one, off time on the next day
    wd = $urandom_range(0, 6);
    d = 32'h1 << (16 + (wd + 1) % 7);
    axi_write(ra(0, REG_TIMER0), d | 32'h59f, RESP_OKAY);
    axi_write(ra(0, REG_TIMER0 + 4'h1), d | 32'h1, RESP_OKAY);
    axi_write(ra(0, REG_FUNC), 32'h9, RESP_OKAY);
    axi_write(ra(0, REG_MODE), 32'(RLY_MODE_AUTO), RESP_OKAY);
    axi_write(ADDR_CLOCK, {13'h0, 3'(wd), 5'h0, 11'h59e}, RESP_OKAY);
    repeat (300) @(negedge clk);
    check_relay(0, 1'b0);
    d = 32'h1 << (16 + wd);
    axi_write(ra(0, REG_TIMER0), d | 32'h59f, RESP_OKAY);
    axi_write(ADDR_CLOCK, {13'h0, 3'(wd), 5'h0, 11'h59e}, RESP_OKAY);
    wait_relay(0, 1'b1, 300);
    axi_write(ra(0, REG_MODE), 32'(RLY_MODE_OFF), RESP_OKAY);
    wait_relay(0, 1'b0, 10);
    axi_write(ra(0, REG_MODE), 32'(RLY_MODE_AUTO), RESP_OKAY);
    wait_relay(0, 1'b1, 10);
    wait_relay(0, 1'b0, 400);
    // evening on output 1: a short shadow must not count as dusk
    @(posedge clk) pv_level <= 16'h0200;
    axi_write(ADDR_CTRL, 32'h0102_0100, RESP_OKAY);
    axi_write(ra(1, REG_EVE), 32'h0005_0001, RESP_OKAY);
    axi_write(ra(1, REG_FUNC), 32'h1, RESP_OKAY);
    axi_write(ra(1, REG_MODE), 32'(RLY_MODE_AUTO), RESP_OKAY);
    @(posedge clk) pv_level <= 16'h0010;
    repeat (30) @(posedge clk);
    pv_level <= 16'h0200;
    check_rd(ADDR_STATUS, '0, 32'h1_0000, RESP_OKAY);
    @(posedge clk) pv_level <= 16'h0010;
    wait_relay(1, 1'b1, 700);
    check_rd(ADDR_STATUS, 32'h1_0000, 32'h1_0000, RESP_OKAY);
    // dawn ends the request long before its five minutes run out
    @(posedge clk) pv_level <= 16'h0200;
    wait_relay(1, 1'b0, 400);
    check_rd(ADDR_STATUS, 32'h2_0000, 32'h3_0000, RESP_OKAY);
    // second night: both windows end by the learned dawn, still in the dark
    axi_write(ra(0, REG_NIGHT), 32'h0001_0001, RESP_OKAY);
    axi_write(ra(0, REG_FUNC), 32'h2, RESP_OKAY);
    axi_write(ra(2, REG_MORN), 32'h0001_0001, RESP_OKAY);
    axi_write(ra(2, REG_FUNC), 32'h4, RESP_OKAY);
    axi_write(ra(2, REG_MODE), 32'(RLY_MODE_AUTO), RESP_OKAY);
    @(posedge clk) pv_level <= 16'h0010;
    wait_relay(2, 1'b1, 700);
    wait_relay(0, 1'b1, 200);
    wait_relay(2, 1'b0, 200);
    wait_relay(0, 1'b0, 200);
    check_rd(ADDR_STATUS, 32'h1_0000, 32'h1_0005, RESP_OKAY);
    end_of_test();
  end
endmodule // rly_relay_ctrl_tb_top
